// ---- shared/cbe_consts.svh ----
// Constants for the conditional branch evaluator
`ifndef CBE_CONSTS_SVH
`define CBE_CONSTS_SVH

`define CBE_PC_WIDTH 16
`define CBE_OFFSET_WIDTH 7
`define CBE_PC_RESET 16'h0000
`define CBE_TAKEN_CYCLES 2
`define CBE_NOT_TAKEN_CYCLES 1

`endif

// ---- shared/cbe_pkg.sv ----
// Types shared by the conditional branch evaluator
package cbe_pkg;

	typedef enum logic [2:0] {
		CBE_OP_NOT_EQUAL,
		CBE_OP_CARRY_SET,
		CBE_OP_CARRY_CLEAR,
		CBE_OP_SAME_OR_HIGHER,
		CBE_OP_LOWER,
		CBE_OP_MINUS,
		CBE_OP_PLUS,
		CBE_OP_GREATER_EQUAL_SIGNED
	} cbe_op_t;

	typedef struct packed {
		logic zero;
		logic carry;
		logic negative;
		logic overflow;
	} cbe_flags_t;

	typedef struct packed {
		cbe_op_t op;
		logic [6:0] offset;
	} cbe_instr_t;

endpackage

// ---- src/cbe_branch_eval.sv ----
// Conditional relative-branch evaluator and program counter update
// Operation
// - Not-equal: jump to counter plus offset plus one when zero is 0.
// - Carry-clear: jump to counter plus offset plus one when carry is 0.
// - Same-or-higher: jump when carry is 0, like carry-clear.
// - Lower: jump to counter plus offset plus one when carry is 1.
// - Minus: jump when negative is 1, else fall through.
// - Plus: jump when negative is 0, else fall through.
// - Signed greater-equal: jump when negative xor overflow is 0.
`timescale 1ns/10ps
`include "cbe_consts.svh"

module cbe_branch_eval #(
	parameter int PC_WIDTH = `CBE_PC_WIDTH,
	parameter int OFFSET_WIDTH = `CBE_OFFSET_WIDTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic instr_valid,
	input wire cbe_pkg::cbe_instr_t instr,
	input wire cbe_pkg::cbe_flags_t flags,
	output logic instr_ready,
	output logic [PC_WIDTH-1:0] program_counter,
	output logic branch_taken,
	output logic done,
	output cbe_pkg::cbe_flags_t flags_out
);
	import cbe_pkg::*;

	typedef enum logic [0:0] {
		CBE_IDLE,
		CBE_TAKE
	} cbe_state_t;

	// Widths the datapath cannot serve are refused at elaboration
	if (OFFSET_WIDTH != `CBE_OFFSET_WIDTH) begin : g_bad_offset
		$error("cbe_branch_eval: offset width must be seven");
	end

	if (PC_WIDTH < 8 || PC_WIDTH > 22) begin : g_bad_pc
		$error("cbe_branch_eval: program counter width out of range");
	end

	if (OFFSET_WIDTH >= PC_WIDTH) begin : g_bad_ratio
		$error("cbe_branch_eval: offset not narrower than counter");
	end

	// The two-state machine only serves the one and two clock timing
	if (`CBE_TAKEN_CYCLES != 2 || `CBE_NOT_TAKEN_CYCLES != 1)
	begin : g_bad_timing
		$error("cbe_branch_eval: unsupported cycle counts");
	end

	localparam logic [PC_WIDTH-1:0] PC_ONE = PC_WIDTH'(1);
	localparam logic [PC_WIDTH-1:0] PC_RESET = PC_WIDTH'(`CBE_PC_RESET);

	cbe_state_t state_ff;
	cbe_state_t nxt_state;
	logic [PC_WIDTH-1:0] pc_ff;
	logic [PC_WIDTH-1:0] nxt_pc;
	logic [PC_WIDTH-1:0] target_ff;
	logic [PC_WIDTH-1:0] nxt_target;
	logic taken_ff;
	logic nxt_taken;
	logic done_ff;
	logic nxt_done;
	cbe_flags_t flags_ff;
	cbe_flags_t nxt_flags;

	// Op decode
	wire logic op_not_equal = (instr.op == CBE_OP_NOT_EQUAL);
	wire logic op_carry_set = (instr.op == CBE_OP_CARRY_SET);
	wire logic op_carry_clear = (instr.op == CBE_OP_CARRY_CLEAR);
	wire logic op_same_or_higher = (instr.op == CBE_OP_SAME_OR_HIGHER);
	wire logic op_lower = (instr.op == CBE_OP_LOWER);
	wire logic op_minus = (instr.op == CBE_OP_MINUS);
	wire logic op_plus = (instr.op == CBE_OP_PLUS);
	wire logic op_ge_signed = (instr.op == CBE_OP_GREATER_EQUAL_SIGNED);

	// Per-op branch conditions on the flags seen at accept
	wire logic flag_signed_lt = flags.negative ^ flags.overflow;
	wire logic cond_not_equal = op_not_equal && !flags.zero;
	wire logic cond_carry_set = op_carry_set && flags.carry;
	wire logic cond_carry_clear = op_carry_clear && !flags.carry;
	wire logic cond_same_or_higher =
		op_same_or_higher && !flags.carry;
	wire logic cond_lower = op_lower && flags.carry;
	wire logic cond_minus = op_minus && flags.negative;
	wire logic cond_plus = op_plus && !flags.negative;
	wire logic cond_ge_signed = op_ge_signed && !flag_signed_lt;

	// Ops are one-hot, so at most one term is ever set
	wire logic cond =
		cond_not_equal ||
		cond_carry_set ||
		cond_carry_clear ||
		cond_same_or_higher ||
		cond_lower ||
		cond_minus ||
		cond_plus ||
		cond_ge_signed;

	// Offset counts in words and may point backwards
	wire logic [PC_WIDTH-1:0] offset_ext;

	for (genvar b = 0; b < PC_WIDTH; b++) begin : g_ext
		if (b < OFFSET_WIDTH) begin : g_low
			assign offset_ext[b] = instr.offset[b];
		end else begin : g_sign
			assign offset_ext[b] = instr.offset[OFFSET_WIDTH-1];
		end
	end

	// Both sums wrap at the counter width, as the fetch address does
	wire logic [PC_WIDTH-1:0] pc_next_seq = pc_ff + PC_ONE;
	wire logic [PC_WIDTH-1:0] pc_target = pc_ff + offset_ext + PC_ONE;

	wire logic idle = (state_ff == CBE_IDLE);
	wire logic refill = (state_ff == CBE_TAKE);
	wire logic accept = instr_valid && idle;
	wire logic accept_taken = accept && cond;
	wire logic accept_fall = accept && !cond;

	// A taken branch spends a second clock refilling, so no new instruction
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CBE_IDLE: begin
				if (accept_taken) begin
					nxt_state = CBE_TAKE;
				end
			end
			CBE_TAKE: begin
				nxt_state = CBE_IDLE;
			end
		endcase
	end

	// Target is latched at accept, so the offset may move during the refill
	assign nxt_target = accept ? pc_target : target_ff;

	// Counter loads the target only in the refill clock
	assign nxt_pc = refill ? target_ff :
		(accept_fall ? pc_next_seq : pc_ff);

	assign nxt_taken = refill;
	assign nxt_done = accept_fall || refill;
	assign nxt_flags = accept ? flags : flags_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= CBE_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc_ff <= PC_RESET;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			target_ff <= '0;
		end else begin
			target_ff <= nxt_target;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			taken_ff <= 1'b0;
		end else begin
			taken_ff <= nxt_taken;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign instr_ready = idle;
	assign program_counter = pc_ff;
	assign branch_taken = taken_ff;
	assign done = done_ff;

	// Copy of the flags seen at accept; branches never write status
	assign flags_out = flags_ff;
endmodule

// ---- testbench/cbe_branch_eval_assertions.sv ----
// Checker for the branch evaluator ports
`timescale 1ns/10ps
module cbe_chk #(parameter int PC_WIDTH = 16) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic instr_valid,
	input wire cbe_pkg::cbe_instr_t instr,
	input wire cbe_pkg::cbe_flags_t flags,
	input wire logic instr_ready,
	input wire logic [PC_WIDTH-1:0] program_counter,
	input wire logic branch_taken,
	input wire logic done,
	input wire cbe_pkg::cbe_flags_t flags_out
);
	import cbe_pkg::*;
	wire acc = instr_valid && instr_ready;
	wire n = flags.negative;
	wire c = flags.carry;
	wire z = flags.zero;
	wire nv = flags.negative ^ flags.overflow;
	// Taken condition per op code, op 0 in bit 0
	wire [7:0] cv = {~(n ^ flags.overflow), ~n, n, c, ~c, ~c, c, ~flags.zero};
	wire hit = cv[instr.op];
	wire [PC_WIDTH-1:0] tg = program_counter + PC_WIDTH'(1)
		+ {{(PC_WIDTH-7){instr.offset[6]}}, instr.offset};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_nt;
		acc && !hit |=> done && !branch_taken
			&& program_counter == $past(program_counter) + PC_WIDTH'(1);
	endproperty
	a_nt: assert property (p_nt) else $error("fall through wrong");
	property p_tk;
		acc && hit |=> !instr_ready && !done ##1 branch_taken && done
			&& program_counter == $past(tg, 2);
	endproperty
	a_tk: assert property (p_tk) else $error("branch wrong");
	property p_fl;
		acc |=> flags_out == $past(flags);
	endproperty
	a_fl: assert property (p_fl) else $error("flags changed");
	property p_rst;
		disable iff (1'b0)
		rst |=> program_counter == '0 && !done && !branch_taken
			&& instr_ready;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_ne;
		acc && instr.op == CBE_OP_NOT_EQUAL |=> done == $past(z);
	endproperty
	a_ne: assert property (p_ne) else $error("not-equal wrong");
	property p_cc;
		acc && instr.op == CBE_OP_CARRY_CLEAR |=> done == $past(c);
	endproperty
	a_cc: assert property (p_cc) else $error("carry-clear wrong");
	property p_sh;
		acc && instr.op == CBE_OP_SAME_OR_HIGHER |=> done == $past(c);
	endproperty
	a_sh: assert property (p_sh) else $error("same-or-higher wrong");
	property p_lo;
		acc && instr.op == CBE_OP_LOWER |=> done == !$past(c);
	endproperty
	a_lo: assert property (p_lo) else $error("lower wrong");
	property p_mi;
		acc && instr.op == CBE_OP_MINUS |=> done == !$past(n);
	endproperty
	a_mi: assert property (p_mi) else $error("minus wrong");
	property p_pl;
		acc && instr.op == CBE_OP_PLUS |=> done == $past(n);
	endproperty
	a_pl: assert property (p_pl) else $error("plus wrong");
	property p_ge;
		acc && instr.op == CBE_OP_GREATER_EQUAL_SIGNED
			|=> done == $past(nv);
	endproperty
	a_ge: assert property (p_ge) else $error("signed ge wrong");
endmodule
bind cbe_branch_eval cbe_chk #(.PC_WIDTH(PC_WIDTH)) cbe_chk_i (
	.clk_sys(clk_sys),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr(instr),
	.flags(flags),
	.instr_ready(instr_ready),
	.program_counter(program_counter),
	.branch_taken(branch_taken),
	.done(done),
	.flags_out(flags_out)
);

// ---- testbench/tb_cbe_branch_eval.sv ----
// Bench for the branch evaluator
`timescale 1ns/10ps
`include "cbe_consts.svh"
module tb_cbe_branch_eval;
	import cbe_pkg::*;
	logic clk_sys = 0, rst = 1, instr_valid = 0;
	cbe_instr_t instr = '0;
	cbe_flags_t flags = '0;
	wire instr_ready, branch_taken, done;
	cbe_flags_t flags_out;
	wire [15:0] program_counter;
	int err_count = 0, num_checks = 0, cyc = 0;
	logic [7:0] m [4] = '{8'hcd, 8'hb2, 8'h4d, 8'h2d};
	cbe_flags_t fv [4] = '{4'h0, 4'hf, 4'h1, 4'h2};
	always #5 clk_sys = ~clk_sys;
	cbe_branch_eval cbe_branch_eval_i (.clk_sys, .rst, .instr_valid,
		.instr, .flags, .instr_ready, .program_counter, .branch_taken,
		.done, .flags_out);
	task chk(input logic [15:0] a, input logic [15:0] b);
		num_checks++;
		if (a !== b) begin
			$display("[ERR] %0t %h %h", $time, a, b);
			err_count++;
		end
	endtask
	task br(cbe_op_t op, cbe_flags_t f, logic [6:0] k, logic tk);
		logic [15:0] e;
		@(negedge clk_sys);
		e = program_counter + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
		instr_valid = 1;
		instr = '{op, k};
		flags = f;
		@(negedge clk_sys);
		instr_valid = 0;
		chk(16'(flags_out), 16'(f));
		chk(16'(instr_ready), 16'(!tk));
		// Second cycle of a taken branch
		if (tk) @(negedge clk_sys);
		chk(program_counter, e);
		chk(16'({done, branch_taken}), 16'({1'b1, tk}));
	endtask
	task br_hold;
		logic [15:0] e;
		@(negedge clk_sys);
		e = program_counter + 16'h0006;
		instr_valid = 1;
		instr = '{CBE_OP_NOT_EQUAL, 7'h05};
		flags = '0;
		@(negedge clk_sys);
		// Request held while busy must be ignored
		instr = '{CBE_OP_LOWER, 7'h7f};
		chk(16'(instr_ready), 16'h0000);
		@(negedge clk_sys);
		instr_valid = 0;
		chk(program_counter, e);
		chk(16'({done, branch_taken}), 16'h0003);
		@(negedge clk_sys);
		chk(program_counter, e);
		chk(16'(done), 16'h0000);
	endtask
	task mid_reset;
		@(negedge clk_sys);
		rst = 1;
		@(negedge clk_sys);
		rst = 0;
		chk(program_counter, `CBE_PC_RESET);
		chk(16'({done, branch_taken, instr_ready}), 16'h0001);
		br(CBE_OP_PLUS, 4'h0, 7'h02, 1'b1);
	endtask
	task give_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (++cyc > 2000) begin
			err_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 0;
		for (int j = 0; j < 4; j++)
			for (int i = 0; i < 8; i++)
				br(cbe_op_t'(i), fv[j], i[0] ? 7'h40 : 7'h3f,
					m[j][i]);
		br_hold;
		mid_reset;
		// Ops above
		// and the signed and plus cases
		give_verdict;
	end
endmodule
